// [design/sarseq_conv_timer.sv]
// Conversion timer: counts oscillator cycles for one conversion
`timescale 1ns/10ps
module sarseq_conv_timer
	import sarseq_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       load,
	input  wire logic       abort,
	input  wire logic [2:0] time_code,
	output logic            expire
);

	typedef struct packed {
		logic [SARSEQ_CNT_W-1:0] cnt;
		logic                    run;
		logic                    expire;
	} sarseq_tmr_t;

	sarseq_tmr_t st_reg;
	sarseq_tmr_t st_next;
	logic [SARSEQ_CNT_W-1:0] load_val;

	// Cycle count per code; reserved codes fall back to the shortest time
	always_comb begin
		case (time_code)
			3'h2:    load_val = SARSEQ_CYC_010;
			3'h3:    load_val = SARSEQ_CYC_011;
			3'h4:    load_val = SARSEQ_CYC_100;
			3'h5:    load_val = SARSEQ_CYC_101;
			3'h6:    load_val = SARSEQ_CYC_110;
			default: load_val = SARSEQ_CYC_000;
		endcase
	end

	// Expire lands exactly load_val+1 cycles after the load cycle
	always_comb begin
		st_next = st_reg;
		st_next.expire = 1'b0;
		if (abort) begin
			st_next.run = 1'b0;
		end else if (load) begin
			st_next.run = 1'b1;
			st_next.cnt = load_val;
		end else if (st_reg.run) begin
			st_next.cnt = st_reg.cnt - 11'h001;
			if (st_reg.cnt == 11'h001) begin
				st_next.run = 1'b0;
				st_next.expire = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign expire = st_reg.expire;

endmodule

// [design/sarseq_top.sv]
// Converter sequencer: AHB-Lite registers, mode control, result capture
`timescale 1ns/10ps
//
// Contract
// - Start bit begins a conversion and clears itself once begun.
// - Mode 00 off, 01 single start, 11 repeat, 10 reserved.
// - Analog input disable bit: 0 enables inputs, 1 disables all.
// - Channel codes 0000-0111 select inputs 0-7; higher codes reserved.
// - Standby resets both control registers and blocks writes meanwhile.
// - Ladder bit 0 connects only during conversion, 1 always.
// - Time codes 000,010-110 give 39..1248 cycles; 001,111 reserved.
// - Result bits 9:2 in high register, 1:0 in status bits 7:6.
// - Reading the high result clears done; read status first.
// - Busy set at start, cleared at finish and on standby.
// - Status bits 3:0 unused and unstable.
// - Single mode: one conversion per start, store, done, interrupt together.
// - Repeat mode restarts at once after each completion.
// - Mode 00 stops repeat at once; interrupted result is not stored.
// - New start clears done; old result kept until new completion.
// - Standby abandons conversion; no resume until software restarts.
module sarseq_top
	import sarseq_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        standby_mode,
	input  wire logic [9:0]  core_result,
	output logic [3:0]       channel_select,
	output logic             analog_input_disable,
	output logic             ladder_connect,
	output logic             conv_active,
	output logic             conv_done_irq
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                    start;
		logic [1:0]              mode;
		logic                    ain_dis;
		logic [3:0]              chan;
		logic                    ladder;
		logic                    fix1;
		logic [2:0]              ack;
		logic                    fix0;
		logic                    busy;
		logic                    done;
		logic [9:0]              res;
		logic                    irq;
		logic                    wr_pend;
		logic [SARSEQ_ADDR_W-3:0] wr_idx;
		logic [7:0]              rdata;
		logic [9:0]              sync1;
		logic [9:0]              sync2;
	} sarseq_state_t;

	sarseq_state_t st_reg;
	sarseq_state_t st_next;

	logic                     addr_take;
	logic                     rd_take;
	logic                     wr_take;
	logic [SARSEQ_ADDR_W-3:0] idx;
	logic                     rd_high;
	logic                     mode_ok;
	logic                     begin_conv;
	logic                     restart;
	logic                     stop_conv;
	logic                     expire;
	logic                     complete;
	logic                     tmr_load;
	logic                     tmr_abort;

	// ****************************************************************
	// Bus address phase decode
	// ****************************************************************
	// Word writes only; other write sizes are taken but leave registers alone; reads of any size are served
	assign addr_take = hsel && htrans[1] && hready;
	assign idx       = haddr[SARSEQ_ADDR_W-1:2];
	assign rd_take   = addr_take && !hwrite;
	assign wr_take   = addr_take && hwrite && (hsize == 3'h2);
	assign rd_high   = rd_take && (idx == SARSEQ_IDX_RES_HIGH);

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// ****************************************************************
	// Sequencing terms
	// ****************************************************************
	// Only single and repeat codes convert; reserved 10 acts like off
	assign mode_ok    = (st_reg.mode == SARSEQ_MODE_SINGLE)
		|| (st_reg.mode == SARSEQ_MODE_REPEAT);
	assign complete   = expire && st_reg.busy && mode_ok && !standby_mode;
	assign begin_conv = st_reg.start && mode_ok && !standby_mode;
	assign restart    = complete && (st_reg.mode == SARSEQ_MODE_REPEAT);
	assign stop_conv  = st_reg.busy && (!mode_ok || standby_mode);
	assign tmr_load   = begin_conv || restart;
	assign tmr_abort  = stop_conv;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.irq = 1'b0;

		// Two flops ahead of the core result, it comes from the analog side
		st_next.sync1 = core_result;
		st_next.sync2 = st_reg.sync1;

		// Write data phase lands one cycle after the address phase
		st_next.wr_pend = wr_take;
		st_next.wr_idx  = idx;
		if (st_reg.wr_pend && !standby_mode) begin
			if (st_reg.wr_idx == SARSEQ_IDX_CTRL_PRIMARY) begin
				st_next.start   = hwdata[SARSEQ_C1_START];
				st_next.mode    = hwdata[SARSEQ_C1_MODE_LSB +: 2];
				st_next.ain_dis = hwdata[SARSEQ_C1_AIN_DIS];
				st_next.chan    = hwdata[SARSEQ_C1_CHAN_LSB +: 4];
			end else if (st_reg.wr_idx == SARSEQ_IDX_TIMING_CTRL) begin
				st_next.ladder = hwdata[SARSEQ_C2_LADDER];
				st_next.fix1   = hwdata[SARSEQ_C2_FIX1];
				st_next.ack    = hwdata[SARSEQ_C2_ACK_LSB +: 3];
				st_next.fix0   = hwdata[SARSEQ_C2_FIX0];
			end
		end

		// Start bit never lingers: taken or dropped the cycle after
		if (st_reg.start) begin
			st_next.start = 1'b0;
		end

		// Reading the high result clears done; a completion wins
		if (rd_high) begin
			st_next.done = 1'b0;
		end

		if (begin_conv) begin
			st_next.busy = 1'b1;
			st_next.done = 1'b0;
		end

		if (complete) begin
			st_next.res  = st_reg.sync2;
			st_next.done = 1'b1;
			st_next.irq  = 1'b1;
			st_next.busy = restart;
		end

		// Mode off abandons the conversion without storing
		if (stop_conv) begin
			st_next.busy = 1'b0;
		end

		// Standby holds controls at reset, drops results and busy
		if (standby_mode) begin
			st_next.start   = 1'b0;
			st_next.mode    = SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_MODE_LSB +: 2];
			st_next.ain_dis = SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_AIN_DIS];
			st_next.chan    = SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_CHAN_LSB +: 4];
			st_next.ladder  = SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_LADDER];
			st_next.fix1    = SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_FIX1];
			st_next.ack     = SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_ACK_LSB +: 3];
			st_next.fix0    = SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_FIX0];
			st_next.busy    = 1'b0;
			st_next.done    = 1'b0;
			st_next.res     = 10'h000;
		end

		// Read data captured from the next state, so a write just ahead is seen
		st_next.rdata = 8'h00;
		if (rd_take) begin
			if (idx == SARSEQ_IDX_CTRL_PRIMARY) begin
				st_next.rdata = {st_next.start, st_next.mode, st_next.ain_dis,
					st_next.chan};
			end else if (idx == SARSEQ_IDX_TIMING_CTRL) begin
				st_next.rdata = {2'h0, st_next.ladder, st_next.fix1, st_next.ack,
					st_next.fix0};
			end else if (idx == SARSEQ_IDX_RES_LOW_STAT) begin
				st_next.rdata = {st_next.res[1:0], st_next.done, st_next.busy,
					4'h0};
			end else if (idx == SARSEQ_IDX_RES_HIGH) begin
				st_next.rdata = st_next.res[9:2];
			end else begin
				st_next.rdata = 8'h00;
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg         <= '0;
			st_reg.mode    <= SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_MODE_LSB +: 2];
			st_reg.ain_dis <= SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_AIN_DIS];
			st_reg.chan    <= SARSEQ_CTRL_PRIMARY_RST[SARSEQ_C1_CHAN_LSB +: 4];
			st_reg.ladder  <= SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_LADDER];
			st_reg.fix1    <= SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_FIX1];
			st_reg.ack     <= SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_ACK_LSB +: 3];
			st_reg.fix0    <= SARSEQ_TIMING_CTRL_RST[SARSEQ_C2_FIX0];
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Conversion timer
	// ****************************************************************
	sarseq_conv_timer i_sarseq_conv_timer (
		.clock     (clock),
		.rstn      (rstn),
		.load      (tmr_load),
		.abort     (tmr_abort),
		.time_code (st_reg.ack),
		.expire    (expire)
	);

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Ladder follows busy unless held on; standby forces busy low anyway
	assign hrdata               = {24'h000000, st_reg.rdata};
	assign channel_select       = st_reg.chan;
	assign analog_input_disable = st_reg.ain_dis;
	assign ladder_connect       = st_reg.ladder || st_reg.busy;
	assign conv_active          = st_reg.busy;
	assign conv_done_irq        = st_reg.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_start_clears;
		@(posedge clock) disable iff (!rstn)
		st_reg.start |=> !st_reg.start;
	endproperty
	a_start_clears: assert property (p_start_clears)
		else $error("start bit did not clear");

	property p_busy_on_start;
		@(posedge clock) disable iff (!rstn)
		(st_reg.start && mode_ok && !standby_mode) |=> st_reg.busy && !st_reg.done;
	endproperty
	a_busy_on_start: assert property (p_busy_on_start)
		else $error("busy not set at start");

	property p_irq_with_done;
		@(posedge clock) disable iff (!rstn)
		conv_done_irq |-> st_reg.done && $past(complete);
	endproperty
	a_irq_with_done: assert property (p_irq_with_done)
		else $error("interrupt without done");

	property p_irq_pulse;
		@(posedge clock) disable iff (!rstn)
		conv_done_irq |=> !conv_done_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("interrupt longer than one cycle");

	property p_result_stored;
		@(posedge clock) disable iff (!rstn)
		conv_done_irq |-> st_reg.res == $past(st_reg.sync2);
	endproperty
	a_result_stored: assert property (p_result_stored)
		else $error("stored result differs from core result");

	property p_standby_reset;
		@(posedge clock) disable iff (!rstn)
		standby_mode |=> (st_reg.chan == 4'h0) && st_reg.ain_dis && !st_reg.busy
			&& (st_reg.mode == SARSEQ_MODE_OFF) && (st_reg.ack == 3'h0);
	endproperty
	a_standby_reset: assert property (p_standby_reset)
		else $error("controls not reset in standby");

	property p_off_no_store;
		@(posedge clock) disable iff (!rstn)
		(st_reg.mode == SARSEQ_MODE_OFF && !standby_mode) |=> $stable(st_reg.res);
	endproperty
	a_off_no_store: assert property (p_off_no_store)
		else $error("result stored while mode off");

	property p_read_clears_done;
		@(posedge clock) disable iff (!rstn)
		(rd_high && !complete && !begin_conv) |=> !st_reg.done;
	endproperty
	a_read_clears_done: assert property (p_read_clears_done)
		else $error("done survived high result read");

	property p_repeat_continues;
		@(posedge clock) disable iff (!rstn)
		(complete && st_reg.mode == SARSEQ_MODE_REPEAT) |=> st_reg.busy;
	endproperty
	a_repeat_continues: assert property (p_repeat_continues)
		else $error("repeat mode did not restart");

	property p_ladder_busy;
		@(posedge clock) disable iff (!rstn)
		st_reg.busy |-> ladder_connect;
	endproperty
	a_ladder_busy: assert property (p_ladder_busy)
		else $error("ladder off during conversion");

	// Mode off mid-run must drop the conversion without a store or request
	property p_stop_discards;
		@(posedge clock) disable iff (!rstn)
		(st_reg.busy && !mode_ok && !standby_mode) |=> !st_reg.busy && !conv_done_irq
			&& $stable(st_reg.res);
	endproperty
	a_stop_discards: assert property (p_stop_discards)
		else $error("stopped conversion was stored");

	property p_single_ends;
		@(posedge clock) disable iff (!rstn)
		(complete && st_reg.mode == SARSEQ_MODE_SINGLE) |=> !st_reg.busy && st_reg.done
			&& conv_done_irq;
	endproperty
	a_single_ends: assert property (p_single_ends)
		else $error("single conversion did not finish cleanly");

	property p_restart_keeps_result;
		@(posedge clock) disable iff (!rstn)
		(begin_conv && !complete) |=> $stable(st_reg.res) && !st_reg.done;
	endproperty
	a_restart_keeps_result: assert property (p_restart_keeps_result)
		else $error("new start disturbed the stored result");

endmodule

// [pkg/sarseq_pkg.sv]
// Constants shared by the converter sequencer and its conversion timer
package sarseq_pkg;

	// ****************************************************************
	// Register map: printed indices, byte address is four times index
	// ****************************************************************
	localparam logic [7:0] SARSEQ_IDX_CTRL_PRIMARY = 8'h1C;
	localparam logic [7:0] SARSEQ_IDX_TIMING_CTRL  = 8'h1D;
	localparam logic [7:0] SARSEQ_IDX_RES_LOW_STAT = 8'h1E;
	localparam logic [7:0] SARSEQ_IDX_RES_HIGH     = 8'h1F;
	localparam int         SARSEQ_ADDR_W           = 10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SARSEQ_C1_START    = 7;
	localparam int SARSEQ_C1_MODE_LSB = 5;
	localparam int SARSEQ_C1_AIN_DIS  = 4;
	localparam int SARSEQ_C1_CHAN_LSB = 0;
	localparam int SARSEQ_C2_LADDER   = 5;
	localparam int SARSEQ_C2_FIX1     = 4;
	localparam int SARSEQ_C2_ACK_LSB  = 1;
	localparam int SARSEQ_C2_FIX0     = 0;
	localparam int SARSEQ_ST_RES_LSB  = 6;
	localparam int SARSEQ_ST_DONE     = 5;
	localparam int SARSEQ_ST_BUSY     = 4;

	// ****************************************************************
	// Reset values and mode codes
	// ****************************************************************
	localparam logic [7:0] SARSEQ_CTRL_PRIMARY_RST = 8'h10;
	localparam logic [7:0] SARSEQ_TIMING_CTRL_RST  = 8'h10;
	localparam logic [1:0] SARSEQ_MODE_OFF         = 2'h0;
	localparam logic [1:0] SARSEQ_MODE_SINGLE      = 2'h1;
	localparam logic [1:0] SARSEQ_MODE_RSVD        = 2'h2;
	localparam logic [1:0] SARSEQ_MODE_REPEAT      = 2'h3;

	// ****************************************************************
	// Conversion times in oscillator cycles
	// ****************************************************************
	localparam int         SARSEQ_CNT_W    = 11;
	localparam logic [10:0] SARSEQ_CYC_000 = 11'h027;
	localparam logic [10:0] SARSEQ_CYC_010 = 11'h04E;
	localparam logic [10:0] SARSEQ_CYC_011 = 11'h09C;
	localparam logic [10:0] SARSEQ_CYC_100 = 11'h138;
	localparam logic [10:0] SARSEQ_CYC_101 = 11'h270;
	localparam logic [10:0] SARSEQ_CYC_110 = 11'h4E0;

endpackage

// [test/sarseq_core_model.sv]
// Behavioural converter core: result from channel and completion count
`timescale 1ns/10ps
module sarseq_core_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [3:0] channel_select,
	input  wire logic       analog_input_disable,
	input  wire logic       conv_active,
	input  wire logic       conv_done_irq,
	output logic [9:0]      core_result
);
	logic [6:0] seq_reg;

	// Idle or disabled inputs give a moving value, so a stale capture shows
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seq_reg <= 7'h00;
			core_result <= 10'h155;
		end else begin
			if (conv_done_irq)
				seq_reg <= seq_reg + 7'h01;
			if (conv_active && !analog_input_disable)
				core_result <= {channel_select[2:0], seq_reg};
			else
				core_result <= ~core_result;
		end
	end
endmodule

// [test/sarseq_tb_top.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module sarseq_tb_top;
	import sarseq_pkg::*;
	localparam logic [7:0] C1 = SARSEQ_IDX_CTRL_PRIMARY;
	localparam logic [7:0] TC = SARSEQ_IDX_TIMING_CTRL;
	localparam logic [7:0] RL = SARSEQ_IDX_RES_LOW_STAT;
	localparam logic [7:0] RH = SARSEQ_IDX_RES_HIGH;
	logic        clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
	logic        standby_mode, analog_input_disable, ladder_connect;
	logic        conv_active, conv_done_irq;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  channel_select;
	logic [6:0]  k;
	logic [9:0]  core_result;
	logic [10:0] ncyc [8] = '{SARSEQ_CYC_000, SARSEQ_CYC_000, SARSEQ_CYC_010,
		SARSEQ_CYC_011, SARSEQ_CYC_100, SARSEQ_CYC_101, SARSEQ_CYC_110, SARSEQ_CYC_000};
	logic [31:0] haddr, hwdata, hrdata;
	int          err_count, n_tests;

	// Single slave: its ready is the bus ready
	assign hready = hreadyout;

	sarseq_top i_sarseq_top (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .standby_mode(standby_mode),
		.core_result(core_result), .channel_select(channel_select),
		.analog_input_disable(analog_input_disable), .ladder_connect(ladder_connect),
		.conv_active(conv_active), .conv_done_irq(conv_done_irq));

	sarseq_core_model i_sarseq_core_model (.clock(clock), .rstn(rstn),
		.channel_select(channel_select), .analog_input_disable(analog_input_disable),
		.conv_active(conv_active), .conv_done_irq(conv_done_irq), .core_result(core_result));

	// ****************************************************************
	// Common tasks
	// ****************************************************************
	task automatic tally_and_finish();
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single word transfer; waits on ready in both phases
	task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= we;
		hsize <= 3'h2;
		haddr <= {22'h0, idx, 2'h0};
		do begin
			@(posedge clock);
		end while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do begin
			@(posedge clock);
		end while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", hresp, 1'b0);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask

	task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] msk,
		input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 8'h00, x);
		chk(nm, x & msk, exp);
	endtask

	// Waits for a completion; a run to the limit means none came
	task automatic wait_irq(input int lim, input logic busy, output int cyc);
		cyc = 0;
		do begin
			@(posedge clock);
			#1;
			cyc++;
			if (cyc == 5)
				chk("ladder_busy", {ladder_connect, conv_active}, {busy, busy});
		end while (conv_done_irq !== 1'b1 && cyc < lim);
		if (cyc < lim) begin
			@(posedge clock);
			#1;
			chk("irq_pulse", conv_done_irq, 1'b0);
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_reset();
		chk("pins_rst", {ladder_connect, conv_active, conv_done_irq, analog_input_disable,
			channel_select}, 8'h10);
		rdc("c1_rst", C1, 32'hFFFFFFFF, 32'h10);
		rdc("tc_rst", TC, 32'hFFFFFFFF, 32'h10);
		rdc("rh_rst", RH, 32'hFFFFFFFF, 32'h0);
		rdc("rl_rst", RL, 32'hFFFFFFF0, 32'h0);
		wr(8'h10, 8'h5A);
		rdc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
		wr(TC, 8'h30);
		#1;
		chk("ladder_on", ladder_connect, 1'b1);
		wr(TC, 8'h10);
		#1;
		chk("ladder_off", ladder_connect, 1'b0);
		wr(C1, 8'h17);
		#1;
		chk("ain_off", {analog_input_disable, channel_select}, 5'h17);
	endtask

	task automatic t_single(input logic [2:0] code);
		logic [9:0] res;
		int         cyc;
		res = {code, k};
		wr(TC, {3'h0, 1'b1, code, 1'b0});
		wr(C1, {3'h1, 2'h0, code});
		#1;
		chk("chan", {analog_input_disable, channel_select}, {2'h0, code});
		wr(C1, {3'h5, 2'h0, code});
		wait_irq(1400, 1'b1, cyc);
		chk("latency", cyc, ncyc[code] + 11'h002);
		chk("busy_end", conv_active, 1'b0);
		rdc("status", RL, 32'hF0, {res[1:0], 6'h20});
		rdc("start_clr", C1, 32'hFF, {3'h1, 2'h0, code});
		rdc("res_high", RH, 32'hFF, res[9:2]);
		rdc("done_clr", RL, 32'h20, 32'h0);
		k++;
	endtask

	task automatic t_restart();
		logic [9:0] old;
		int         cyc;
		old = {3'h5, k};
		wr(C1, 8'h25);
		wr(C1, 8'hA5);
		wait_irq(1400, 1'b1, cyc);
		k++;
		wr(C1, 8'hA5);
		rdc("done_new", RL, 32'hE0, {old[1:0], 6'h00});
		rdc("keep_old", RH, 32'hFF, old[9:2]);
		wait_irq(1400, 1'b1, cyc);
		rdc("res_new", RH, 32'hFF, {3'h5, k[6:2]});
		k++;
	endtask

	task automatic t_repeat();
		logic [9:0] last;
		int         cyc;
		wr(TC, 8'h10);
		wr(C1, 8'h62);
		wr(C1, 8'hE2);
		wait_irq(1400, 1'b1, cyc);
		wait_irq(1400, 1'b1, cyc);
		chk("period", cyc, SARSEQ_CYC_000);
		chk("busy_rep", conv_active, 1'b1);
		last = {3'h2, k + 7'h01};
		k = k + 7'h02;
		wr(C1, 8'h02);
		wait_irq(60, 1'b0, cyc);
		chk("stopped", cyc, 60);
		rdc("no_store", RH, 32'hFF, last[9:2]);
		wr(C1, 8'hC2);
		wait_irq(60, 1'b0, cyc);
		chk("rsvd_mode", cyc, 60);
	endtask

	task automatic t_standby();
		int cyc;
		wr(TC, 8'h18);
		wr(C1, 8'h23);
		wr(C1, 8'hA3);
		repeat (20) @(posedge clock);
		chk("busy_run", conv_active, 1'b1);
		standby_mode <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk("busy_stby", conv_active, 1'b0);
		wr(C1, 8'h25);
		rdc("c1_stby", C1, 32'hFFFFFFFF, 32'h10);
		rdc("tc_stby", TC, 32'hFFFFFFFF, 32'h10);
		chk("pins_stby", {analog_input_disable, channel_select}, 5'h10);
		standby_mode <= 1'b0;
		wait_irq(400, 1'b0, cyc);
		chk("no_resume", cyc, 400);
		rdc("res_clr", RH, 32'hFF, 32'h0);
	endtask

	// ****************************************************************
	// Clock, watchdog and main sequence
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Whole run is a few thousand cycles; this allows ample margin
	initial begin
		#200000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		err_count = 0;
		n_tests = 0;
		k = 7'h00;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		standby_mode = 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		for (int c = 0; c < 8; c++)
			t_single(c[2:0]);
		t_restart();
		t_repeat();
		t_standby();
		tally_and_finish();
	end
endmodule
